// [core/rsm_mode_ctrl.sv]
// range-shift mode supervisor: mode selection, gating, forcing, gear control
// ************************************************************
// Summary of operation
// - policy: manual only, automatic only, or both
// - mode from wired switch or network request
// - push button press toggles manual/automatic
// - push button start mode set by configuration
// - toggling allowed everywhere or neutral only
// - direction engagement granted only while button held
// - direction engagement forces manual mode
// - bump lever forces manual and shifts one step
// - lever top gives automatic, lower gives manual
// - loaded gives manual, empty gives automatic
// - change-over always, standstill, or standstill/lever-ge-gear
// - separate gating for each change direction
// - mode changes at once, downshifts still overspeed-checked
// - loaded vehicle may force manual mode
// - low range may force manual mode
// - shift delay after direction, lockup, shift events
// - manual gear follows lever within safety limits
// - overspeed lights lamp and shifts up
// - overspeeding downshift refused, lamp lit in manual mode only
// - mode state echoed in status message
// - automatic gear between lowest and lever position
// ************************************************************
`timescale 1ns/10ps
`default_nettype none
module rsm_mode_ctrl
  import rsm_pkg::*;
#(
  parameter int CYC_PER_MS = rsm_pkg::RSM_CYC_PER_MS
)(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  input  wire rsm_pkg::rsm_pins_t   pins_i,
  input  wire rsm_pkg::rsm_cfg_t    cfg_i,
  input  wire rsm_pkg::rsm_veh_t    veh_i,
  input  wire rsm_pkg::rsm_net_req_t mode_request_net_message_i,
  output var  logic [2:0]           gear_o,
  output var  logic [1:0]           dir_o,
  output var  logic                 auto_mode_o,
  output var  logic                 warn_lamp_o,
  output var  logic                 shift_blocked_o,
  output var  rsm_pkg::rsm_echo_t   status_echo_net_message_o
);
  import rsm_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    rsm_pins_t  s1;
    rsm_pins_t  s2;
    logic       init_done;
    logic       btn_prev;
    logic [1:0] bump_prev;
    logic       grant;
    logic [1:0] dir;
    logic       tog_auto;
    logic       net_auto;
    logic       req_prev;
    logic       man_latch;
    logic       auto_m;
    logic [2:0] gear;
    logic       warn;
    rsm_echo_t  echo;
  } rsm_state_t;

  rsm_state_t r_reg;
  rsm_state_t r_next;
  rsm_pins_t  p;
  logic       busy;
  logic       press;
  logic       bump_up_evt;
  logic       bump_dn_evt;
  logic       bump_evt;
  logic       grant;
  logic       engage_evt;
  logic       dchg_evt;
  logic       req_auto;
  logic       pol_auto;
  logic       force_lvl;
  logic       force_evt;
  logic       want_auto;
  logic       co_ok;
  rsm_co_t    co_sel;
  logic       up_req;
  logic       dn_req;
  logic       shift;
  logic       restart;

  assign p = r_reg.s2;

  // ************************************************************
  // input events and direction grant
  // ************************************************************
  always_comb
  begin
    press       = p.mode_sw & ~r_reg.btn_prev;
    bump_up_evt = cfg_i.bump_forces_man & p.bump_up & ~r_reg.bump_prev[1];
    bump_dn_evt = cfg_i.bump_forces_man & p.bump_dn & ~r_reg.bump_prev[0];
    bump_evt    = bump_up_evt | bump_dn_evt;
    // engagement needs the held button when so configured
    grant = (p.lever_dir != RSM_DIR_N) &&
            (!cfg_i.eng_needs_btn || p.mode_sw);
    engage_evt = grant & ~r_reg.grant;
    dchg_evt   = grant & r_reg.grant & (p.lever_dir != r_reg.dir);
  end

  // ************************************************************
  // mode request and change-over gating
  // ************************************************************
  always_comb
  begin
    unique case (cfg_i.src)
      RSM_SRC_SW:    req_auto = p.mode_sw;
      RSM_SRC_NET:   req_auto = r_reg.net_auto;
      RSM_SRC_BTN:   req_auto = r_reg.tog_auto;
      RSM_SRC_LEVER: req_auto = (p.lever_gear == RSM_GEAR_MAX);
      RSM_SRC_LOAD:  req_auto = ~p.loaded;
      default:       req_auto = 1'b0;
    endcase
    unique case (cfg_i.policy)
      RSM_POL_MAN:  pol_auto = 1'b0;
      RSM_POL_AUTO: pol_auto = 1'b1;
      RSM_POL_BOTH: pol_auto = req_auto;
      default:      pol_auto = 1'b0;
    endcase
    force_lvl = (cfg_i.load_forces_man & p.loaded) |
                (cfg_i.low_forces_man & p.low_range);
    force_evt = (cfg_i.eng_forces_man & engage_evt) | bump_evt;
    want_auto = pol_auto & ~force_lvl & ~force_evt & ~r_reg.man_latch;
    // separate condition for each direction of change
    co_sel = r_reg.auto_m ? cfg_i.co_a2m : cfg_i.co_m2a;
    unique case (co_sel)
      RSM_CO_ALWAYS:   co_ok = 1'b1;
      RSM_CO_STAND:    co_ok = veh_i.standstill;
      RSM_CO_STAND_GE: co_ok = veh_i.standstill ||
                               (p.lever_gear >= r_reg.gear);
      default:         co_ok = 1'b0;
    endcase
  end

  // ************************************************************
  // gear request
  // ************************************************************
  // overspeed first, then bump, then manual or automatic tracking
  always_comb
  begin
    up_req = 1'b0;
    dn_req = 1'b0;
    if (veh_i.ovs_cur)
      up_req = (r_reg.gear < RSM_GEAR_MAX);
    else if (bump_up_evt)
      up_req = (r_reg.gear < RSM_GEAR_MAX);
    else if (bump_dn_evt)
      dn_req = (r_reg.gear > RSM_GEAR_MIN);
    else if (!r_reg.auto_m)
    begin
      up_req = (p.lever_gear > r_reg.gear);
      dn_req = (p.lever_gear < r_reg.gear);
    end
    else
    begin
      // automatic stays within lowest gear and lever position
      up_req = (veh_i.auto_up && r_reg.gear < p.lever_gear) ||
               (r_reg.gear < cfg_i.lowest_auto);
      dn_req = (r_reg.gear > p.lever_gear) ||
               (veh_i.auto_dn && r_reg.gear > cfg_i.lowest_auto);
    end
    // never step outside the gear span, e.g. unsynced lever 0 after reset
    up_req = up_req & (r_reg.gear < RSM_GEAR_MAX);
    dn_req = dn_req & (r_reg.gear > RSM_GEAR_MIN);
    // a downshift into overspeed is withheld
    shift   = ~busy & (up_req | (dn_req & ~veh_i.ovs_down));
    restart = shift | engage_evt | dchg_evt | veh_i.lockup_off;
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    r_next           = r_reg;
    r_next.s1        = pins_i;
    r_next.s2        = r_reg.s1;
    r_next.btn_prev  = p.mode_sw;
    r_next.bump_prev = {p.bump_up, p.bump_dn};
    r_next.grant     = grant;
    r_next.dir       = grant ? p.lever_dir : RSM_DIR_N;
    r_next.req_prev  = req_auto;
    r_next.init_done = 1'b1;
    // push button start mode and toggling
    if (!r_reg.init_done)
      r_next.tog_auto = cfg_i.btn_init_auto;
    else if (press && (!cfg_i.tog_neutral_only ||
             p.lever_dir == RSM_DIR_N))
      r_next.tog_auto = ~r_reg.tog_auto;
    if (mode_request_net_message_i.valid)
      r_next.net_auto = mode_request_net_message_i.auto_req;
    // momentary forcings hold manual until a fresh auto request
    if (force_evt)
    begin
      r_next.man_latch = 1'b1;
      r_next.tog_auto  = 1'b0;
    end
    else if (req_auto && !r_reg.req_prev)
      r_next.man_latch = 1'b0;
    // forced manual bypasses gating, others change at once when allowed
    if (!want_auto && (force_lvl || force_evt))
      r_next.auto_m = 1'b0;
    else if (want_auto != r_reg.auto_m && co_ok)
      r_next.auto_m = want_auto;
    if (shift)
      r_next.gear = up_req ? 3'(r_reg.gear + 3'h1)
                           : 3'(r_reg.gear - 3'h1);
    // lamp for overspeed or a refused driver downshift
    r_next.warn = veh_i.ovs_cur |
                  (dn_req & veh_i.ovs_down & ~r_reg.auto_m);
    r_next.echo.auto_mode  = r_next.auto_m;
    r_next.echo.forced_man = force_lvl | r_next.man_latch;
    r_next.echo.gear       = r_next.gear;
    r_next.echo.warn       = r_next.warn;
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      r_reg      <= '0;
      r_reg.gear <= RSM_GEAR_RST;
      r_reg.echo.gear <= RSM_GEAR_RST;
    end
    else
      r_reg <= r_next;
  end

  // ************************************************************
  // delay timer and outputs
  // ************************************************************
  rsm_delay_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_dly (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .restart_i  (restart),
    .delay_ms_i (cfg_i.delay_ms),
    .busy_o     (busy)
  );

  assign gear_o                    = r_reg.gear;
  assign dir_o                     = r_reg.dir;
  assign auto_mode_o               = r_reg.auto_m;
  assign warn_lamp_o               = r_reg.warn;
  assign shift_blocked_o           = busy;
  assign status_echo_net_message_o = r_reg.echo;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_pol_man;
    cfg_i.policy == RSM_POL_MAN |=> !auto_mode_o;
  endproperty
  a_pol_man: assert property (p_pol_man) else $error("auto in manual-only policy");

  property p_load_force;
    cfg_i.load_forces_man && p.loaded |=> !auto_mode_o;
  endproperty
  a_load_force: assert property (p_load_force) else $error("loaded not manual");

  property p_low_force;
    cfg_i.low_forces_man && p.low_range |=> !auto_mode_o;
  endproperty
  a_low_force: assert property (p_low_force) else $error("low range not manual");

  property p_blocked;
    shift_blocked_o |=> $stable(gear_o);
  endproperty
  a_blocked: assert property (p_blocked) else $error("shift during delay");

  property p_restart;
    $changed(gear_o) |-> shift_blocked_o;
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted");

  property p_refuse_dn;
    !r_reg.auto_m && dn_req && veh_i.ovs_down |=> warn_lamp_o && $stable(gear_o);
  endproperty
  a_refuse_dn: assert property (p_refuse_dn) else $error("bad downshift taken");

  property p_ovs;
    veh_i.ovs_cur && !shift_blocked_o && gear_o < RSM_GEAR_MAX
      |=> warn_lamp_o && gear_o == $past(gear_o) + 3'h1;
  endproperty
  a_ovs: assert property (p_ovs) else $error("overspeed not handled");

  property p_track;
    !auto_mode_o && !shift_blocked_o && !veh_i.ovs_cur && !bump_evt &&
      p.lever_gear > gear_o |=> gear_o == $past(gear_o) + 3'h1;
  endproperty
  a_track: assert property (p_track) else $error("gear not tracking lever");

  property p_echo;
    ##1 status_echo_net_message_o.auto_mode == auto_mode_o;
  endproperty
  a_echo: assert property (p_echo) else $error("echo mismatch");

  property p_grant;
    cfg_i.eng_needs_btn && !p.mode_sw |=> dir_o == RSM_DIR_N;
  endproperty
  a_grant: assert property (p_grant) else $error("engaged without button");

  property p_dchg;
    dchg_evt |=> shift_blocked_o;
  endproperty
  a_dchg: assert property (p_dchg) else $error("direction change not delayed");

  property p_bump;
    bump_up_evt && !shift_blocked_o && gear_o < RSM_GEAR_MAX
      |=> !auto_mode_o && gear_o == $past(gear_o) + 3'h1;
  endproperty
  a_bump: assert property (p_bump) else $error("bump not handled");

  property p_lever_src;
    cfg_i.src == RSM_SRC_LEVER && cfg_i.policy == RSM_POL_BOTH &&
      cfg_i.co_a2m == RSM_CO_ALWAYS && p.lever_gear != RSM_GEAR_MAX |=> !auto_mode_o;
  endproperty
  a_lever_src: assert property (p_lever_src) else $error("lever below top not manual");

  property p_auto_top;
    auto_mode_o && !veh_i.ovs_cur && !bump_evt && gear_o >= p.lever_gear &&
      gear_o >= cfg_i.lowest_auto |=> gear_o <= $past(gear_o);
  endproperty
  a_auto_top: assert property (p_auto_top) else $error("auto above lever");

  property p_auto_low;
    auto_mode_o && !bump_evt && gear_o <= cfg_i.lowest_auto &&
      gear_o <= p.lever_gear |=> gear_o >= $past(gear_o);
  endproperty
  a_auto_low: assert property (p_auto_low) else $error("auto below lowest gear");
endmodule : rsm_mode_ctrl
`default_nettype wire

// [core/rsm_pkg.sv]
// shared constants and carrier types of the range-shift mode supervisor
package rsm_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int RSM_CLK_NS      = 4;          // 250 MHz period
  localparam int RSM_MS_NS       = 1_000_000;  // one millisecond
  localparam int RSM_CYC_PER_MS  = RSM_MS_NS / RSM_CLK_NS;
  localparam int RSM_PRE_W       = 18;
  localparam int RSM_DLY_W       = 12;
  localparam logic [RSM_DLY_W-1:0] RSM_DLY_MS_DEF = 12'h7D0; // 2000 ms

  // ************************************************************
  // gears and directions
  // ************************************************************
  localparam logic [2:0] RSM_GEAR_MIN = 3'h1;
  localparam logic [2:0] RSM_GEAR_MAX = 3'h4;
  localparam logic [2:0] RSM_GEAR_RST = 3'h1;
  localparam logic [1:0] RSM_DIR_N    = 2'h0;
  localparam logic [1:0] RSM_DIR_F    = 2'h1;
  localparam logic [1:0] RSM_DIR_R    = 2'h2;

  // ************************************************************
  // configuration encodings
  // ************************************************************
  typedef enum logic [1:0] {RSM_POL_MAN, RSM_POL_AUTO, RSM_POL_BOTH} rsm_pol_t;
  typedef enum logic [2:0] {RSM_SRC_SW, RSM_SRC_NET, RSM_SRC_BTN, RSM_SRC_LEVER,
                            RSM_SRC_LOAD} rsm_src_t;
  typedef enum logic [1:0] {RSM_CO_ALWAYS, RSM_CO_STAND, RSM_CO_STAND_GE} rsm_co_t;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [2:0] lever_gear;
    logic [1:0] lever_dir;
    logic       mode_sw;
    logic       loaded;
    logic       low_range;
    logic       bump_up;
    logic       bump_dn;
  } rsm_pins_t;

  typedef struct packed {
    rsm_pol_t   policy;
    rsm_src_t   src;
    logic       btn_init_auto;
    logic       tog_neutral_only;
    logic       eng_needs_btn;
    logic       eng_forces_man;
    logic       bump_forces_man;
    logic       load_forces_man;
    logic       low_forces_man;
    rsm_co_t    co_m2a;
    rsm_co_t    co_a2m;
    logic [2:0] lowest_auto;
    logic [RSM_DLY_W-1:0] delay_ms;
  } rsm_cfg_t;

  typedef struct packed {
    logic standstill;
    logic ovs_cur;
    logic ovs_down;
    logic auto_up;
    logic auto_dn;
    logic lockup_off;
  } rsm_veh_t;

  typedef struct packed {
    logic valid;
    logic auto_req;
  } rsm_net_req_t;

  typedef struct packed {
    logic       auto_mode;
    logic       forced_man;
    logic [2:0] gear;
    logic       warn;
  } rsm_echo_t;
endpackage : rsm_pkg

// [core/rsm_delay_timer.sv]
// range-shift delay timer counting milliseconds after each restart
`timescale 1ns/10ps
`default_nettype none
module rsm_delay_timer
  import rsm_pkg::*;
#(
  parameter int CYC_PER_MS = rsm_pkg::RSM_CYC_PER_MS
)(
  input  wire logic                          mclk_i,
  input  wire logic                          rst_n_i,
  input  wire logic                          restart_i,
  input  wire logic [rsm_pkg::RSM_DLY_W-1:0] delay_ms_i,
  output var  logic                          busy_o
);
  import rsm_pkg::*;

  typedef struct packed {
    logic [RSM_PRE_W-1:0] pre;
    logic [RSM_DLY_W-1:0] ms;
    logic                 busy;
  } rsm_tmr_t;

  rsm_tmr_t r_reg;
  rsm_tmr_t r_next;
  logic     ms_tick;

  // ************************************************************
  // next state
  // ************************************************************
  // restart always wins and counts from zero
  always_comb
  begin
    r_next  = r_reg;
    ms_tick = (r_reg.pre == RSM_PRE_W'(CYC_PER_MS - 1));
    if (restart_i)
    begin
      r_next.pre  = '0;
      r_next.ms   = '0;
      r_next.busy = 1'b1;
    end
    else if (r_reg.busy)
    begin
      if (r_reg.ms >= delay_ms_i)
        r_next.busy = 1'b0;
      else if (ms_tick)
      begin
        r_next.pre = '0;
        r_next.ms  = RSM_DLY_W'(r_reg.ms + 1'b1);
      end
      else
        r_next.pre = RSM_PRE_W'(r_reg.pre + 1'b1);
    end
  end

  // state register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign busy_o = r_reg.busy;
endmodule : rsm_delay_timer
`default_nettype wire

// [sim/rsm_driver_model.sv]
// driver-side partner model: shift lever, mode switch and network node
`timescale 1ns/10ps
`default_nettype none
module rsm_driver_model
  import rsm_pkg::*;
(
  input  wire logic                  mclk_i,
  input  wire rsm_pkg::rsm_pins_t    pins_cmd_i,
  input  wire logic                  net_send_i,
  input  wire logic                  net_auto_i,
  output var  rsm_pkg::rsm_pins_t    pins_o,
  output var  rsm_pkg::rsm_net_req_t net_o
);
  import rsm_pkg::*;

  rsm_pins_t    pins_hold;
  rsm_net_req_t net_hold = '0;

  // take the bench command on the rising edge so it may change freely
  always @(posedge mclk_i)
  begin
    pins_hold <= pins_cmd_i;
    net_hold.valid <= net_send_i;
    // idle frame: request bit toggles so a stale value is never trusted
    net_hold.auto_req <= net_send_i ? net_auto_i : ~net_hold.auto_req;
  end

  // switches and frames change on the falling edge
  always @(negedge mclk_i)
  begin
    pins_o <= pins_hold;
    net_o  <= net_hold;
  end
endmodule // rsm_driver_model
`default_nettype wire

// [sim/rsm_mode_ctrl_test.sv]
// self-checking bench of the range-shift mode supervisor
`timescale 1ns/10ps
`default_nettype none
module rsm_mode_ctrl_test;
  import rsm_pkg::*;
  localparam int CPM = 4; // short millisecond for simulation
  logic         mclk_i;
  logic         rst_n_i;
  rsm_pins_t    pins_cmd;
  rsm_pins_t    pins;
  logic         net_send;
  logic         net_auto;
  rsm_net_req_t net_req;
  rsm_cfg_t     cfg;
  rsm_cfg_t     c;
  rsm_veh_t     veh;
  logic [2:0]   gear;
  logic [1:0]   dir;
  logic         auto_mode;
  logic         warn;
  logic         blocked;
  rsm_echo_t    echo;
  int           errors;
  int           cmp_count;

  rsm_driver_model drv (
    .mclk_i     (mclk_i),
    .pins_cmd_i (pins_cmd),
    .net_send_i (net_send),
    .net_auto_i (net_auto),
    .pins_o     (pins),
    .net_o      (net_req)
  );

  rsm_mode_ctrl #(.CYC_PER_MS(CPM)) DUT (
    .mclk_i                     (mclk_i),
    .rst_n_i                    (rst_n_i),
    .pins_i                     (pins),
    .cfg_i                      (cfg),
    .veh_i                      (veh),
    .mode_request_net_message_i (net_req),
    .gear_o                     (gear),
    .dir_o                      (dir),
    .auto_mode_o                (auto_mode),
    .warn_lamp_o                (warn),
    .shift_blocked_o            (blocked),
    .status_echo_net_message_o  (echo)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic rsm_cfg_t base(input rsm_pol_t p, input rsm_src_t s);
    rsm_cfg_t b;
    b = '0;
    b.policy = p;
    b.src = s;
    b.lowest_auto = 3'h1;
    b.delay_ms = 12'h004;
    return b;
  endfunction

  // new configuration is only applied under reset
  task automatic restart(input rsm_cfg_t nc, input int hold);
    rst_n_i = 1'b0;
    cfg = nc;
    pins_cmd = '0;
    pins_cmd.lever_gear = 3'h1;
    veh = '0;
    cyc(hold);
    rst_n_i = 1'b1;
    cyc(6);
  endtask

  task automatic wait_free();
    int n;
    n = 0;
    while (blocked !== 1'b0 && n < 200)
    begin
      cyc(1);
      n++;
    end
    check(8'(n < 200), 8'h01);
  endtask

  task automatic press();
    pins_cmd.mode_sw = 1'b1;
    cyc(4);
    pins_cmd.mode_sw = 1'b0;
    cyc(5);
  endtask

  task automatic net_tx(input logic a);
    net_auto = a;
    net_send = 1'b1;
    cyc(1);
    net_send = 1'b0;
    cyc(5);
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial
  begin
    errors = 0;
    cmp_count = 0;
    net_send = 1'b0;
    net_auto = 1'b0;
    restart(base(RSM_POL_MAN, RSM_SRC_SW), 16);
    check(8'(gear), 8'h01);
    check(8'(dir), 8'h00);
    check(8'(auto_mode), 8'h00);
    check(8'(warn), 8'h00);
    check(8'(blocked), 8'h00);
    check(8'(echo), 8'h02);
    // manual tracking, delay, restart on lockup
    pins_cmd.lever_gear = 3'h2;
    cyc(5);
    check(8'(gear), 8'h02);
    check(8'(blocked), 8'h01);
    pins_cmd.lever_gear = 3'h3;
    cyc(4);
    check(8'(gear), 8'h02);
    veh.lockup_off = 1'b1;
    cyc(1);
    veh.lockup_off = 1'b0;
    cyc(12);
    check(8'(blocked), 8'h01);
    wait_free();
    cyc(3);
    check(8'(gear), 8'h03);
    // overspeeding downshift refused, then overspeed upshift
    wait_free();
    veh.ovs_down = 1'b1;
    pins_cmd.lever_gear = 3'h2;
    cyc(5);
    check(8'(gear), 8'h03);
    check(8'(warn), 8'h01);
    veh.ovs_down = 1'b0;
    cyc(5);
    check(8'(gear), 8'h02);
    veh.ovs_cur = 1'b1;
    cyc(3);
    check(8'(warn), 8'h01);
    wait_free();
    cyc(2);
    check(8'(gear), 8'h03);
    veh.ovs_cur = 1'b0;
    // each policy with the wired switch
    for (int p = 0; p < 3; p++)
    begin
      restart(base(rsm_pol_t'(p), RSM_SRC_SW), 4);
      pins_cmd.mode_sw = 1'b1;
      cyc(5);
      check(8'(auto_mode), 8'(p != 0));
      check(8'(echo.auto_mode), 8'(p != 0));
      pins_cmd.mode_sw = 1'b0;
      cyc(5);
      check(8'(auto_mode), 8'(p == 1));
    end
    // separate change-over gating per direction
    c = base(RSM_POL_BOTH, RSM_SRC_SW);
    c.co_m2a = RSM_CO_STAND;
    restart(c, 4);
    pins_cmd.mode_sw = 1'b1;
    cyc(5);
    check(8'(auto_mode), 8'h00);
    veh.standstill = 1'b1;
    cyc(3);
    check(8'(auto_mode), 8'h01);
    veh.standstill = 1'b0;
    pins_cmd.mode_sw = 1'b0;
    cyc(5);
    check(8'(auto_mode), 8'h00);
    // standstill or lever at least gear
    c.co_m2a = RSM_CO_STAND_GE;
    restart(c, 4);
    pins_cmd.lever_gear = 3'h2;
    cyc(5);
    wait_free();
    veh.ovs_down = 1'b1;
    pins_cmd.lever_gear = 3'h1;
    pins_cmd.mode_sw = 1'b1;
    cyc(6);
    check(8'(auto_mode), 8'h00);
    check(8'(gear), 8'h02);
    pins_cmd.lever_gear = 3'h3;
    cyc(5);
    check(8'(auto_mode), 8'h01);
    // network request
    restart(base(RSM_POL_BOTH, RSM_SRC_NET), 4);
    net_tx(1'b1);
    check(8'(auto_mode), 8'h01);
    net_tx(1'b0);
    check(8'(auto_mode), 8'h00);
    // push button toggling, start mode and neutral-only
    c = base(RSM_POL_BOTH, RSM_SRC_BTN);
    c.btn_init_auto = 1'b1;
    c.tog_neutral_only = 1'b1;
    restart(c, 4);
    check(8'(auto_mode), 8'h01);
    press();
    check(8'(auto_mode), 8'h00);
    pins_cmd.lever_dir = RSM_DIR_F;
    cyc(5);
    press();
    check(8'(auto_mode), 8'h00);
    pins_cmd.lever_dir = RSM_DIR_N;
    cyc(5);
    press();
    check(8'(auto_mode), 8'h01);
    // engagement only with button held
    c.eng_needs_btn = 1'b1;
    c.tog_neutral_only = 1'b0;
    restart(c, 4);
    pins_cmd.lever_dir = RSM_DIR_F;
    cyc(6);
    check(8'(dir), 8'h00);
    pins_cmd.mode_sw = 1'b1;
    cyc(5);
    check(8'(dir), 8'(RSM_DIR_F));
    // engagement forces manual and starts the delay
    c = base(RSM_POL_BOTH, RSM_SRC_SW);
    c.eng_forces_man = 1'b1;
    restart(c, 4);
    pins_cmd.mode_sw = 1'b1;
    cyc(5);
    pins_cmd.lever_dir = RSM_DIR_F;
    cyc(5);
    check(8'(dir), 8'(RSM_DIR_F));
    check(8'(auto_mode), 8'h00);
    check(8'(blocked), 8'h01);
    // direction change while engaged restarts the delay
    wait_free();
    pins_cmd.lever_dir = RSM_DIR_R;
    cyc(5);
    check(8'(dir), 8'(RSM_DIR_R));
    check(8'(blocked), 8'h01);
    // bump lever forces manual and shifts
    c = base(RSM_POL_BOTH, RSM_SRC_SW);
    c.bump_forces_man = 1'b1;
    restart(c, 4);
    pins_cmd.mode_sw = 1'b1;
    cyc(5);
    pins_cmd.bump_up = 1'b1;
    pins_cmd.lever_gear = 3'h2;
    cyc(3);
    pins_cmd.bump_up = 1'b0;
    cyc(3);
    check(8'(auto_mode), 8'h00);
    check(8'(gear), 8'h02);
    wait_free();
    pins_cmd.bump_dn = 1'b1;
    cyc(3);
    pins_cmd.bump_dn = 1'b0;
    cyc(3);
    check(8'(gear), 8'h01);
    // lever position and load based selection
    restart(base(RSM_POL_BOTH, RSM_SRC_LEVER), 4);
    pins_cmd.lever_gear = 3'h4;
    cyc(5);
    check(8'(auto_mode), 8'h01);
    pins_cmd.lever_gear = 3'h3;
    cyc(5);
    check(8'(auto_mode), 8'h00);
    restart(base(RSM_POL_BOTH, RSM_SRC_LOAD), 4);
    check(8'(auto_mode), 8'h01);
    pins_cmd.loaded = 1'b1;
    cyc(5);
    check(8'(auto_mode), 8'h00);
    // forcings by load and low range
    c = base(RSM_POL_BOTH, RSM_SRC_SW);
    c.load_forces_man = 1'b1;
    c.low_forces_man = 1'b1;
    restart(c, 4);
    pins_cmd.mode_sw = 1'b1;
    pins_cmd.loaded = 1'b1;
    cyc(5);
    check(8'(auto_mode), 8'h00);
    check(8'(echo.forced_man), 8'h01);
    pins_cmd.loaded = 1'b0;
    pins_cmd.low_range = 1'b1;
    cyc(5);
    check(8'(auto_mode), 8'h00);
    // automatic span between lowest gear and lever
    c = base(RSM_POL_BOTH, RSM_SRC_SW);
    c.lowest_auto = 3'h3;
    restart(c, 4);
    pins_cmd.lever_gear = 3'h4;
    pins_cmd.mode_sw = 1'b1;
    cyc(70);
    check(8'(gear), 8'h03);
    pins_cmd.lever_gear = 3'h3;
    veh.auto_up = 1'b1;
    cyc(60);
    check(8'(gear), 8'h03);
    veh.auto_up = 1'b0;
    veh.auto_dn = 1'b1;
    cyc(30);
    check(8'(gear), 8'h03);
    summarize();
  end

  // cut a hang short
  initial
  begin
    repeat (6000) @(posedge mclk_i);
    errors++;
    summarize();
  end
endmodule // rsm_mode_ctrl_test
`default_nettype wire
